/* File: ppf_params.svh */
/*
  Timing counts and reset values for the port pin function block.
  Assumes inclusion by bare name from the port pins module only.
*/
`ifndef PPF_PARAMS_SVH
`define PPF_PARAMS_SVH

`define PPF_DIR_RESET_A     8'h00
`define PPF_DIR_RESET_B     5'h00
`define PPF_DIR_RESET_C     6'h00
`define PPF_OP_DIV          2
`define PPF_USB_DIV         4
`define PPF_START_LONG      4064
`define PPF_START_SHORT     128
`define PPF_ADC_CH_FOUR     3
`define PPF_ADC_CH_FIVE     4

`endif

/* File: ppf_pkg.sv */
/*
  Types shared by the port pin function block.
  Assumes ppf_params.svh is on the include path.
*/
package ppf_pkg;
  typedef enum logic [1:0] {
    PPF_ST_OSC   = 2'b00,
    PPF_ST_RUN   = 2'b01
  } ppf_state_t;
  typedef logic [7:0] ppf_port_a_t;
  typedef logic [4:0] ppf_port_b_t;
  typedef logic [5:0] ppf_port_c_t;
endpackage : ppf_pkg

/* File: ppf_sync_if.sv */
/*
  Interface carrying synchronised pin levels between block modules.
  Assumes one clock domain.
*/
interface ppf_sync_if;
  logic [7:0] pa;
  logic [4:0] pb;
  logic [5:0] pc;
  logic       irq_n;
  logic       rst_n;
  modport src (output pa, pb, pc, irq_n, rst_n);
  modport dst (input pa, pb, pc, irq_n, rst_n);
endinterface : ppf_sync_if

/* File: ppf_pin_sync.sv */
/*
  Two-flop synchroniser for every pin input of the block.
  Assumes asynchronous pin levels; reset values are the idle levels.
*/
module ppf_pin_sync
  import ppf_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       sys_rst,
  input  wire logic [7:0] pa_in,
  input  wire logic [4:0] pb_in,
  input  wire logic [5:0] pc_in,
  input  wire logic       irq_n_in,
  input  wire logic       rst_n_in,
  ppf_sync_if.src         sync
);
  logic [20:0] meta_q;
  logic [20:0] stab_q;

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      meta_q <= 21'h1fffff;
      stab_q <= 21'h1fffff;
    end else begin
      meta_q <= {pa_in, pb_in, pc_in, irq_n_in, rst_n_in};
      stab_q <= meta_q;
    end
  end

  assign sync.pa    = stab_q[20:13];
  assign sync.pb    = stab_q[12:8];
  assign sync.pc    = stab_q[7:2];
  assign sync.irq_n = stab_q[1];
  assign sync.rst_n = stab_q[0];
endmodule : ppf_pin_sync

/* File: ppf_irq_detect.sv */
/*
  Falling-edge or edge-plus-level detector for one interrupt source.
  Assumes a synchronised active-low input.
*/
module ppf_irq_detect (
  input  wire logic core_clk,
  input  wire logic sys_rst,
  input  wire logic lvl_n,
  input  wire logic level_mode,
  output logic      req
);
  logic prev_q;

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      prev_q <= 1'b1;
    end else begin
      prev_q <= lvl_n;
    end
  end

  // A request on the falling edge, or in level mode for as long as the line stays low.
  assign req = (prev_q & ~lvl_n) | (level_mode & ~lvl_n);
endmodule : ppf_irq_detect

/* File: ppf_port_pins.sv */
/*
  Port pin function control: direction, pull-ups, slow edges, pin
  takeover by interrupt, capture and converter functions, clock
  dividers, start-up delay and the bidirectional reset pin.
  Assumes software registers arrive as plain ports on core_clk, and
  that core_clk stands in for the oscillator clock.
*/
// Functional notes
// - All port lines are inputs after any reset; software sets direction.
// - Operating clock enable runs at half the oscillator rate.
// - Low-speed USB bit enable is the oscillator clock divided by four.
// - Hold off after oscillator start for 4064 or 128 cycles.
// - Interrupt triggers on falling edge, or falling edge and low level.
// - Optionally OR port A lines 0-3 into the interrupt, same sensitivity.
// - External low reset pin resets; low-voltage reset drives the pin.
// - Second interrupt enabled makes port A line 4 a separate input.
// - Capture enabled makes port B line 0 the timer capture input.
// - Converter on: port C 0-3 channels, lines 4 and 5 references.
// - Converter on: port B lines 3 and 4 are channels four and five.
// - Port B pull-ups switch under software; port C has none.
// - Slow falling-edge control on port B and port A lines 6 and 7.
// - Port A lines 6 and 7 high sink drive chosen by build option.
`include "ppf_params.svh"
module ppf_port_pins
  import ppf_pkg::*;
#(
  parameter bit          SHORT_START  = 1'b0,
  parameter bit          LEVEL_IRQ    = 1'b0,
  parameter bit          KBD_IRQ      = 1'b0,
  parameter bit          HIGH_SINK    = 1'b0,
  parameter int unsigned START_LONG   = `PPF_START_LONG
)(
  input  wire logic            core_clk,
  input  wire logic            sys_rst,
  input  wire ppf_pkg::ppf_port_a_t pa_in,
  input  wire ppf_pkg::ppf_port_b_t pb_in,
  input  wire ppf_pkg::ppf_port_c_t pc_in,
  input  wire logic            irq_n_in,
  input  wire logic            reset_pin_in,
  input  wire logic            low_voltage_reset,
  input  wire logic            dir_wr_a,
  input  wire logic            dir_wr_b,
  input  wire logic            dir_wr_c,
  input  wire logic            out_wr,
  input  wire logic            cfg_wr,
  input  wire logic [7:0]      wdata_a,
  input  wire logic [4:0]      wdata_b,
  input  wire logic [5:0]      wdata_c,
  input  wire logic            second_irq_en,
  input  wire logic            capture_en,
  input  wire logic            adc_on,
  output ppf_pkg::ppf_port_a_t pa_out,
  output ppf_pkg::ppf_port_a_t pa_oe,
  output ppf_pkg::ppf_port_b_t pb_out,
  output ppf_pkg::ppf_port_b_t pb_oe,
  output ppf_pkg::ppf_port_c_t pc_out,
  output ppf_pkg::ppf_port_c_t pc_oe,
  output ppf_pkg::ppf_port_b_t pb_pullup,
  output ppf_pkg::ppf_port_a_t pa_pullup,
  output logic [6:0]           slow_edge,
  output logic [1:0]           pa_high_sink,
  output ppf_pkg::ppf_port_a_t pa_read,
  output ppf_pkg::ppf_port_b_t pb_read,
  output ppf_pkg::ppf_port_c_t pc_read,
  output logic                 irq_req,
  output logic                 second_irq_req,
  output logic                 timer_capture_input,
  output logic [5:0]           adc_channels,
  output logic                 op_clk_en,
  output logic                 usb_bit_en,
  output logic                 core_run,
  output logic                 reset_pin_out,
  output logic                 reset_pin_oe,
  output logic                 chip_reset
);
  import ppf_pkg::*;

  localparam int unsigned START_CYC =
    SHORT_START ? `PPF_START_SHORT : START_LONG;

  // Every pin level passes two flops before any logic reads it, so a
  // level that changes near an edge cannot split between two readers.
  ppf_sync_if sync ();
  ppf_pin_sync u_sync (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .pa_in    (pa_in),
    .pb_in    (pb_in),
    .pc_in    (pc_in),
    .irq_n_in (irq_n_in),
    .rst_n_in (reset_pin_in),
    .sync     (sync.src)
  );

  // Internal reset from the reset pin, the low-voltage detector or sys_rst.
  // The detector pulls the pin low itself, so circuits sharing the pin
  // see the same reset; the pin is never driven high.
  logic rst_int;
  assign rst_int = chip_reset;

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      chip_reset    <= 1'b1;
      reset_pin_out <= 1'b0;
      reset_pin_oe  <= 1'b0;
    end else begin
      chip_reset    <= ~sync.rst_n | low_voltage_reset;
      reset_pin_out <= 1'b0;
      reset_pin_oe  <= low_voltage_reset;
    end
  end

  // Clock dividers produce one-cycle enables.
  // Both enables come from one counter, so every bit enable coincides
  // with an operating enable.
  logic [1:0] div_q;
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      div_q      <= 2'h0;
      op_clk_en  <= 1'b0;
      usb_bit_en <= 1'b0;
    end else begin
      div_q      <= div_q + 2'h1;
      op_clk_en  <= div_q[0];
      usb_bit_en <= (div_q == 2'(`PPF_USB_DIV - 1));
    end
  end

  // Start-up delay after oscillator start or any reset.
  // The count restarts on every internal reset, so even a short glitch
  // on the reset pin costs the full delay.
  ppf_state_t  st_q;
  logic [11:0] start_q;
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_q     <= PPF_ST_OSC;
      start_q  <= 12'h000;
      core_run <= 1'b0;
    end else if (rst_int) begin
      st_q     <= PPF_ST_OSC;
      start_q  <= 12'h000;
      core_run <= 1'b0;
    end else begin
      case (st_q)
        PPF_ST_OSC: begin
          start_q <= start_q + 12'h001;
          if (start_q == 12'(START_CYC - 1)) begin
            st_q     <= PPF_ST_RUN;
            core_run <= 1'b1;
          end
        end
        PPF_ST_RUN: core_run <= 1'b1;
        default: st_q <= PPF_ST_OSC;
      endcase
    end
  end

  // Software registers: direction, output data, pull-ups, slow edges.
  ppf_port_a_t dir_a_q, dat_a_q, pur_a_q;
  ppf_port_b_t dir_b_q, dat_b_q, pur_b_q;
  ppf_port_c_t dir_c_q, dat_c_q;
  logic [6:0]  slow_q;

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      dir_a_q <= `PPF_DIR_RESET_A;
      dir_b_q <= `PPF_DIR_RESET_B;
      dir_c_q <= `PPF_DIR_RESET_C;
    end else if (rst_int) begin
      dir_a_q <= `PPF_DIR_RESET_A;
      dir_b_q <= `PPF_DIR_RESET_B;
      dir_c_q <= `PPF_DIR_RESET_C;
    end else begin
      if (dir_wr_a) dir_a_q <= wdata_a;
      if (dir_wr_b) dir_b_q <= wdata_b;
      if (dir_wr_c) dir_c_q <= wdata_c;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      dat_a_q <= 8'h00;
      dat_b_q <= 5'h00;
      dat_c_q <= 6'h00;
    end else if (out_wr) begin
      dat_a_q <= wdata_a;
      dat_b_q <= wdata_b;
      dat_c_q <= wdata_c;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pur_a_q <= 8'h00;
      pur_b_q <= 5'h00;
      slow_q  <= 7'h00;
    end else if (rst_int) begin
      pur_a_q <= 8'h00;
      pur_b_q <= 5'h00;
      slow_q  <= 7'h00;
    end else if (cfg_wr) begin
      pur_a_q <= wdata_a;
      pur_b_q <= wdata_b;
      slow_q  <= {wdata_a[7:6], wdata_b};
    end
  end

  // Pin takeover masks: a taken line is never driven as an output.
  ppf_port_b_t take_b;
  ppf_port_c_t take_c;
  ppf_port_a_t take_a;
  // The keyboard lines only feed the interrupt OR; their direction stays
  // with software, so they are not masked here.
  assign take_a = {3'h0, second_irq_en, 4'h0};
  assign take_b = {adc_on, adc_on, 2'h0, capture_en};
  assign take_c = adc_on ? 6'h3f : 6'h00;

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pa_out <= 8'h00;
      pa_oe  <= 8'h00;
      pb_out <= 5'h00;
      pb_oe  <= 5'h00;
      pc_out <= 6'h00;
      pc_oe  <= 6'h00;
    end else begin
      pa_out <= dat_a_q;
      pa_oe  <= dir_a_q & ~take_a;
      pb_out <= dat_b_q;
      pb_oe  <= dir_b_q & ~take_b;
      pc_out <= dat_c_q;
      pc_oe  <= dir_c_q & ~take_c;
    end
  end

  // Pull-ups, slow edges and sink strength; pull-ups off where driven.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pa_pullup    <= 8'h00;
      pb_pullup    <= 5'h00;
      slow_edge    <= 7'h00;
      pa_high_sink <= 2'h0;
    end else begin
      pa_pullup    <= pur_a_q & ~dir_a_q;
      pb_pullup    <= pur_b_q & ~dir_b_q & ~take_b;
      slow_edge    <= slow_q;
      pa_high_sink <= HIGH_SINK ? 2'h3 : 2'h0;
    end
  end

  // Interrupt sources: dedicated pin, optional port A OR, second input.
  // A low keyboard line looks like a low on the pin, so both share one
  // detector and therefore one sensitivity.
  logic irq_any_n;
  logic irq_det;
  logic second_interrupt_input_det;
  assign irq_any_n = sync.irq_n & (KBD_IRQ ? &sync.pa[3:0] : 1'b1);

  ppf_irq_detect u_irq (
    .core_clk   (core_clk),
    .sys_rst    (sys_rst),
    .lvl_n      (irq_any_n),
    .level_mode (LEVEL_IRQ),
    .req        (irq_det)
  );
  ppf_irq_detect u_second_interrupt_input (
    .core_clk   (core_clk),
    .sys_rst    (sys_rst),
    .lvl_n      (sync.pa[4]),
    .level_mode (1'b0),
    .req        (second_interrupt_input_det)
  );

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_req             <= 1'b0;
      second_irq_req      <= 1'b0;
      timer_capture_input <= 1'b1;
      adc_channels        <= 6'h00;
    end else begin
      irq_req             <= irq_det;
      second_irq_req      <= second_irq_en & second_interrupt_input_det;
      timer_capture_input <= capture_en ? sync.pb[0] : 1'b1;
      adc_channels        <= adc_on ? {sync.pb[`PPF_ADC_CH_FIVE],
                                        sync.pb[`PPF_ADC_CH_FOUR],
                                        sync.pc[3:0]} : 6'h00;
    end
  end

  // Pin readback: lines with direction set read their latch, others the pin.
  // Reading the latch keeps a heavily loaded output from reading wrong.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pa_read <= 8'h00;
      pb_read <= 5'h00;
      pc_read <= 6'h00;
    end else begin
      pa_read <= (dir_a_q & dat_a_q) | (~dir_a_q & sync.pa);
      pb_read <= (dir_b_q & dat_b_q) | (~dir_b_q & sync.pb);
      pc_read <= (dir_c_q & dat_c_q) | (~dir_c_q & sync.pc);
    end
  end
endmodule : ppf_port_pins

/* File: ppf_port_pins_sva.sv */
/*
  Port checks for the port pin function block.
  Assumes a bind onto ppf_port_pins and a single clock.
*/
module ppf_port_pins_sva
  import ppf_pkg::*;
(
  input wire logic                 core_clk,
  input wire logic                 sys_rst,
  input wire logic                 chip_reset,
  input wire logic                 core_run,
  input wire ppf_pkg::ppf_port_a_t pa_oe,
  input wire ppf_pkg::ppf_port_b_t pb_oe,
  input wire ppf_pkg::ppf_port_c_t pc_oe,
  input wire logic                 op_clk_en,
  input wire logic                 usb_bit_en,
  input wire logic                 low_voltage_reset,
  input wire logic                 reset_pin_oe,
  input wire logic                 reset_pin_out,
  input wire logic                 adc_on,
  input wire logic                 second_irq_req
);
  timeunit 1ns;
  timeprecision 1ns;
  import ppf_pkg::*;
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // Direction clears one edge into reset and the enables one edge later.
  a_dir_in_reset: assert property (
    chip_reset [*3] |-> pa_oe == '0 && pb_oe == '0 && pc_oe == '0)
    else $error("direction not cleared in reset");
  a_op_half: assert property (
    op_clk_en |=> !op_clk_en ##1 op_clk_en)
    else $error("operating enable not every second cycle");
  a_usb_quarter: assert property (
    usb_bit_en |=> !usb_bit_en [*3] ##1 usb_bit_en)
    else $error("bit enable not every fourth cycle");
  a_start_hold: assert property (
    $fell(chip_reset) |-> !core_run [*8])
    else $error("core runs before start delay");
  a_start_ends: assert property (
    $fell(chip_reset) |-> ##[14:18] core_run)
    else $error("core not running after start delay");
  a_run_in_reset: assert property (
    chip_reset [*2] |-> !core_run)
    else $error("core runs in reset");
  a_lvr_drives: assert property (
    low_voltage_reset [*3] |-> reset_pin_oe && !reset_pin_out)
    else $error("reset pin not driven low");
  a_adc_takeover: assert property (
    adc_on [*3] |-> pc_oe == '0 && pb_oe[4:3] == 2'h0)
    else $error("converter pins still driven");
  a_second_interrupt_input_pulse: assert property (
    second_irq_req |=> !second_irq_req)
    else $error("second interrupt request not a pulse");
endmodule : ppf_port_pins_sva

bind ppf_port_pins ppf_port_pins_sva u_sva (.*);

/* File: ppf_pin_model.sv */
/*
  External circuitry on the port and reset pins.
  Assumes the bench sets the external levels; the reset pin is pulled up.
*/
module ppf_pin_model
  import ppf_pkg::*;
(
  input  wire ppf_pkg::ppf_port_a_t pa_out,
  input  wire ppf_pkg::ppf_port_a_t pa_oe,
  input  wire ppf_pkg::ppf_port_a_t ext_pa,
  input  wire ppf_pkg::ppf_port_b_t pb_out,
  input  wire ppf_pkg::ppf_port_b_t pb_oe,
  input  wire ppf_pkg::ppf_port_b_t ext_pb,
  input  wire ppf_pkg::ppf_port_c_t pc_out,
  input  wire ppf_pkg::ppf_port_c_t pc_oe,
  input  wire ppf_pkg::ppf_port_c_t ext_pc,
  input  wire logic                 reset_pin_out,
  input  wire logic                 reset_pin_oe,
  input  wire logic                 ext_rst_n,
  input  wire logic                 ext_irq_n,
  output logic                      reset_pin_in,
  output logic                      irq_n_in,
  output ppf_pkg::ppf_port_a_t      pa_in,
  output ppf_pkg::ppf_port_b_t      pb_in,
  output ppf_pkg::ppf_port_c_t      pc_in
);
  timeunit 1ns;
  timeprecision 1ns;
  import ppf_pkg::*;
  assign pa_in = (pa_oe & pa_out) | (~pa_oe & ext_pa);
  assign pb_in = (pb_oe & pb_out) | (~pb_oe & ext_pb);
  assign pc_in = (pc_oe & pc_out) | (~pc_oe & ext_pc);
  assign irq_n_in = ext_irq_n;
  // The device output wins; released, the pull-up or the switch sets it.
  assign reset_pin_in = reset_pin_oe ? reset_pin_out : ext_rst_n;
endmodule : ppf_pin_model

/* File: ppf_port_pins_tb_top.sv */
/*
  Self-checking bench for the port pin function block.
  Assumes a shortened start-up count of 16 and keyboard interrupts on.
*/
module ppf_port_pins_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import ppf_pkg::*;
  logic core_clk, sys_rst, irq_n_in, reset_pin_in, low_voltage_reset;
  logic dir_wr_a, dir_wr_b, dir_wr_c, out_wr, cfg_wr, ext_irq_n;
  logic second_irq_en, capture_en, adc_on, irq_req, second_irq_req;
  logic timer_capture_input, op_clk_en, usb_bit_en, core_run;
  logic reset_pin_out, reset_pin_oe, chip_reset, ext_rst_n;
  ppf_port_a_t pa_in, pa_out, pa_oe, pa_pullup, pa_read, wdata_a, ext_pa;
  ppf_port_b_t pb_in, pb_out, pb_oe, pb_pullup, pb_read, wdata_b, ext_pb;
  ppf_port_c_t pc_in, pc_out, pc_oe, pc_read, wdata_c, ext_pc;
  logic [6:0] slow_edge;
  logic [1:0] pa_high_sink;
  logic [5:0] adc_channels;
  int mismatches;
  int compares;
  int n;

  ppf_port_pins #(.KBD_IRQ(1'b1), .START_LONG(16)) DUT (.*);
  ppf_pin_model pins (.*);

  initial begin
    core_clk = 1'b0;
    // The clock stands for an external source on the oscillator input.
    forever #20 core_clk = ~core_clk;
  end

  task automatic cyc(input int k);
    repeat (k) @(posedge core_clk);
    #1;
  endtask : cyc

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic count(input bit sel, input int k);
    n = 0;
    repeat (k) begin
      cyc(1);
      n += int'(sel ? second_irq_req : sel ? 1'b0 : irq_req);
    end
  endtask : count

  task automatic count_clk;
    int a;
    int b;
    a = 0;
    b = 0;
    repeat (40) begin
      cyc(1);
      a += int'(op_clk_en);
      b += int'(usb_bit_en);
    end
    chk(8'(a), 8'h14);
    chk(8'(b), 8'h0a);
  endtask : count_clk

  task automatic t_dir;
    {dir_wr_a, dir_wr_b, dir_wr_c} = 3'b111;
    {wdata_a, wdata_b, wdata_c} = '1;
    cyc(1);
    {dir_wr_a, dir_wr_b, dir_wr_c} = 3'b000;
    cyc(2);
    chk(pa_oe, 8'hff);
    chk(8'(pc_oe), 8'h3f);
    {adc_on, capture_en, second_irq_en} = 3'b111;
    ext_pc = 6'h2a;
    ext_pb = 5'h19;
    cyc(5);
    chk(8'(pc_oe), 8'h00);
    chk(8'(pb_oe), 8'h06);
    chk(pa_oe, 8'hef);
    chk(8'(adc_channels), 8'h3a);
    chk(8'(timer_capture_input), 8'h01);
    ext_pb = 5'h18;
    ext_pa = 8'hef;
    count(1'b1, 6);
    chk(8'(timer_capture_input), 8'h00);
    chk(8'(n), 8'h01);
  endtask : t_dir

  task automatic t_cfg;
    // Pull-ups show only on undriven lines, on port B only untaken ones, so free them first.
    {adc_on, capture_en, second_irq_en} = 3'b000;
    {dir_wr_a, dir_wr_b} = 2'b11;
    {wdata_a, wdata_b} = '0;
    cyc(1);
    {dir_wr_a, dir_wr_b} = 2'b00;
    cfg_wr = 1'b1;
    wdata_a = 8'hc5;
    wdata_b = 5'h0b;
    cyc(1);
    cfg_wr = 1'b0;
    cyc(2);
    chk(pa_pullup, 8'hc5);
    chk(8'(pb_pullup), 8'h0b);
    chk(8'(slow_edge), 8'h6b);
    {dir_wr_a, dir_wr_b, dir_wr_c, out_wr} = 4'hf;
    wdata_a = 8'h0f;
    wdata_b = 5'h03;
    wdata_c = 6'h05;
    cyc(1);
    {dir_wr_a, dir_wr_b, dir_wr_c, out_wr} = 4'h0;
    cyc(4);
    chk(pa_out, 8'h0f);
    chk(8'(pb_out), 8'h03);
    chk(8'(pc_out), 8'h05);
    chk(pa_read, 8'hef);
    chk(8'(pb_read), 8'h1b);
    chk(8'(pc_read), 8'h2f);
    chk(8'(pa_high_sink), 8'h00);
  endtask : t_cfg

  task automatic t_pinrst;
    ext_rst_n = 1'b0;
    cyc(6);
    chk(8'(chip_reset), 8'h01);
    chk(8'(pb_oe), 8'h00);
    chk(8'(pb_pullup), 8'h00);
    ext_rst_n = 1'b1;
    cyc(30);
    chk(8'(core_run), 8'h01);
    low_voltage_reset = 1'b1;
    cyc(6);
    chk(8'(reset_pin_oe), 8'h01);
    chk(8'(chip_reset), 8'h01);
    low_voltage_reset = 1'b0;
    cyc(30);
  endtask : t_pinrst

  task automatic t_irq;
    {adc_on, capture_en, second_irq_en} = 3'b000;
    ext_irq_n = 1'b0;
    count(1'b0, 8);
    chk(8'(n), 8'h01);
    // The pin must settle high first, or its rise hides the line's fall.
    ext_irq_n = 1'b1;
    cyc(4);
    ext_pa = 8'hfe;
    count(1'b0, 8);
    chk(8'(n), 8'h01);
  endtask : t_irq

  task automatic report_and_stop;
    if (mismatches == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop

  initial begin
    #50000;
    mismatches++;
    report_and_stop();
  end

  initial begin
    sys_rst = 1'b1;
    {dir_wr_a, dir_wr_b, dir_wr_c, out_wr, cfg_wr} = '0;
    {wdata_a, wdata_b, wdata_c} = '0;
    {second_irq_en, capture_en, adc_on, low_voltage_reset} = '0;
    {ext_irq_n, ext_rst_n} = 2'b11;
    {ext_pa, ext_pb, ext_pc} = '1;
    cyc(2);
    sys_rst = 1'b0;
    cyc(1);
    chk(pa_oe, 8'h00);
    // The reset pin idles high, so the internal reset ends at once.
    chk(8'(chip_reset), 8'h00);
    cyc(8);
    chk(8'(core_run), 8'h00);
    cyc(30);
    chk(8'(core_run), 8'h01);
    t_dir();
    t_cfg();
    t_pinrst();
    t_irq();
    count_clk();
    report_and_stop();
  end
endmodule : ppf_port_pins_tb_top
